// ### rtl/vsl_sync_lock.sv
`timescale 1ns/10ps
module vsl_sync_lock (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] video_word_in,
  input wire logic line_sync_in_n,
  input wire logic field_sync_in_n,
  input wire logic clock_subcarrier_mode,
  input wire logic embedded_enable,
  input wire logic ntsc_4fsc,
  input wire logic [3:0] comb_select_in,
  input wire logic [1:0] emulate_mode,
  input wire logic eight_bit_mode,
  output logic [9:0] video_word_out,
  output logic decoded_line_sync_out,
  output logic decoded_field_sync_out,
  output logic field_id_out,
  output logic timing_locked,
  output logic [3:0] comb_arch_out
);

  // ****************************************
  // Word alignment
  // ****************************************
  logic [9:0] word_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= 10'h000;
    end else begin
      word_q <= eight_bit_mode ? {video_word_in[9:2], 2'b00} : video_word_in;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      video_word_out <= 10'h000;
    end else begin
      video_word_out <= word_q;
    end
  end

  // ****************************************
  // Embedded reference decoder
  // ****************************************
  vsl_timing_if ref_tim ();

  vsl_ref_decoder u_ref (
    .clock(clock),
    .rst_n(rst_n),
    .word_in(word_q),
    .tim(ref_tim)
  );

  // ****************************************
  // External sync pin synchronisers
  // ****************************************
  logic [2:0] hs_sync_q;
  logic [2:0] vs_sync_q;
  logic hs_level_q;
  logic vs_level_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hs_sync_q <= 3'h7;
      vs_sync_q <= 3'h7;
      hs_level_q <= 1'b1;
      vs_level_q <= 1'b1;
    end else begin
      hs_sync_q <= {hs_sync_q[1:0], line_sync_in_n};
      vs_sync_q <= {vs_sync_q[1:0], field_sync_in_n};
      if (hs_sync_q[1] == hs_sync_q[2]) begin
        hs_level_q <= hs_sync_q[2];
      end
      if (vs_sync_q[1] == vs_sync_q[2]) begin
        vs_level_q <= vs_sync_q[2];
      end
    end
  end

  logic ext_line_start;
  logic ext_field_start;
  assign ext_line_start = (hs_sync_q[1] == hs_sync_q[2]) && !hs_sync_q[2] && hs_level_q;
  assign ext_field_start = (vs_sync_q[1] == vs_sync_q[2]) && !vs_sync_q[2] && vs_level_q;

  logic ext_seen_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_seen_q <= 1'b0;
    end else if (ext_line_start) begin
      ext_seen_q <= 1'b1;
    end
  end

  // ****************************************
  // Source selection
  // ****************************************
  vsl_pkg::vsl_src_t src;

  always_comb begin
    if (embedded_enable && ref_tim.valid) begin
      src = vsl_pkg::VSL_SRC_EMBEDDED;
    end else if (clock_subcarrier_mode && !(ntsc_4fsc && ext_seen_q)) begin
      src = vsl_pkg::VSL_SRC_SEPARATOR;
    end else begin
      src = vsl_pkg::VSL_SRC_EXTERNAL;
    end
  end

  // ****************************************
  // Sync separator
  // ****************************************
  logic sync_tip;
  assign sync_tip = word_q < vsl_pkg::SYNC_LEVEL_THRESH;

  vsl_pkg::vsl_sep_state_t sep_q;
  logic [11:0] tip_len_q;
  logic [11:0] hcnt_q;
  logic [9:0] vcnt_q;
  logic [11:0] line_len_q;
  logic sep_line_start;
  logic sep_field_start;
  logic mid_hit;
  logic in_vgroup;

  assign in_vgroup = vcnt_q <= vsl_pkg::VGROUP_END_LINE;
  assign mid_hit = sync_tip && (tip_len_q == vsl_pkg::SYNC_MIN_WIDTH);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tip_len_q <= 12'h000;
    end else if (sync_tip) begin
      tip_len_q <= tip_len_q + 12'h001;
    end else begin
      tip_len_q <= 12'h000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sep_q <= vsl_pkg::VSL_SEP_SEARCH;
    end else begin
      case (sep_q)
        vsl_pkg::VSL_SEP_SEARCH: begin
          if (tip_len_q == vsl_pkg::SYNC_BROAD_WIDTH) begin
            sep_q <= vsl_pkg::VSL_SEP_LOCK;
          end
        end
        vsl_pkg::VSL_SEP_LOCK: begin
          if (!in_vgroup) begin
            sep_q <= vsl_pkg::VSL_SEP_FLYWHEEL;
          end
        end
        vsl_pkg::VSL_SEP_FLYWHEEL: begin
          if (in_vgroup) begin
            sep_q <= vsl_pkg::VSL_SEP_LOCK;
          end
        end
        default: begin
          sep_q <= vsl_pkg::VSL_SEP_SEARCH;
        end
      endcase
    end
  end

  // Locked lines follow the tip reaching SYNC_MIN_WIDTH only; elsewhere the learned (or, in search, reset) length flywheels
  assign sep_line_start = (sep_q == vsl_pkg::VSL_SEP_LOCK) ? mid_hit
                          : hcnt_q == line_len_q - 12'h001;
  assign sep_field_start = (sep_q == vsl_pkg::VSL_SEP_SEARCH || !in_vgroup)
                           && tip_len_q == vsl_pkg::SYNC_BROAD_WIDTH;

  // ****************************************
  // Line and field counters
  // ****************************************
  logic line_start;
  logic field_start;

  always_comb begin
    case (src)
      vsl_pkg::VSL_SRC_EMBEDDED: begin
        line_start = ref_tim.line_start;
        field_start = ref_tim.field_start;
      end
      vsl_pkg::VSL_SRC_SEPARATOR: begin
        line_start = sep_line_start;
        field_start = sep_field_start;
      end
      default: begin
        line_start = ext_line_start;
        field_start = ext_field_start;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q <= 12'h000;
      line_len_q <= vsl_pkg::LINE_LEN_RESET;
    end else if (line_start) begin
      hcnt_q <= 12'h000;
      if (src == vsl_pkg::VSL_SRC_SEPARATOR && sep_q == vsl_pkg::VSL_SEP_LOCK
          && hcnt_q > vsl_pkg::SYNC_BROAD_WIDTH) begin
        line_len_q <= hcnt_q + 12'h001;
      end
    end else begin
      hcnt_q <= hcnt_q + 12'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vcnt_q <= vsl_pkg::FIELD_LINES_RESET;
    end else if (field_start) begin
      vcnt_q <= 10'h000;
    end else if (line_start) begin
      vcnt_q <= vcnt_q + 10'h001;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      decoded_line_sync_out <= 1'b0;
      decoded_field_sync_out <= 1'b0;
      field_id_out <= 1'b0;
      timing_locked <= 1'b0;
    end else begin
      decoded_line_sync_out <= hcnt_q < vsl_pkg::HSYNC_PULSE_LEN;
      decoded_field_sync_out <= vcnt_q < vsl_pkg::VSYNC_PULSE_LINES;
      if (field_start) begin
        field_id_out <= (src == vsl_pkg::VSL_SRC_EMBEDDED) ? ref_tim.field_id : ~field_id_out;
      end
      timing_locked <= (src == vsl_pkg::VSL_SRC_SEPARATOR) ? sep_q != vsl_pkg::VSL_SEP_SEARCH
                                                          : 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      comb_arch_out <= 4'h0;
    end else begin
      case (vsl_pkg::vsl_emu_t'(emulate_mode))
        vsl_pkg::VSL_EMU_TWO_LINE: comb_arch_out <= {1'b0, comb_select_in[2:0]};
        vsl_pkg::VSL_EMU_SIMPLE: comb_arch_out <= 4'h0;
        default: comb_arch_out <= comb_select_in;
      endcase
    end
  end

endmodule

// ### rtl/vsl_pkg.sv
package vsl_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int unsigned WORD_W = 10;
  localparam int unsigned HCNT_W = 12;
  localparam int unsigned VCNT_W = 10;
  localparam int unsigned COMB_SEL_W = 4;
  localparam int unsigned COMB_COUNT = 16;
  localparam logic [11:0] LINE_LEN_RESET = 12'h6B4;
  localparam logic [9:0] FIELD_LINES_RESET = 10'h107;
  localparam logic [9:0] VGROUP_END_LINE = 10'h009;
  localparam logic [11:0] SYNC_MIN_WIDTH = 12'h020;
  localparam logic [11:0] SYNC_BROAD_WIDTH = 12'h100;
  localparam logic [11:0] HSYNC_PULSE_LEN = 12'h040;
  localparam logic [9:0] VSYNC_PULSE_LINES = 10'h003;
  localparam logic [9:0] SYNC_LEVEL_THRESH = 10'h040;

  // ****************************************
  // Embedded timing word bytes
  // ****************************************
  localparam logic [9:0] REF_PREAMBLE_ONES = 10'h3FF;
  localparam logic [9:0] REF_PREAMBLE_ZERO = 10'h000;
  localparam int unsigned REF_V_BIT = 7;
  localparam int unsigned REF_H_BIT = 6;
  localparam int unsigned REF_F_BIT = 8;

  // ****************************************
  // Timing source, clock mode and emulation selection
  // ****************************************
  typedef enum logic [1:0] {
    VSL_SRC_EMBEDDED = 2'h0,
    VSL_SRC_EXTERNAL = 2'h1,
    VSL_SRC_SEPARATOR = 2'h2
  } vsl_src_t;

  typedef enum logic [1:0] {
    VSL_CLK_LINE_LOCKED = 2'h0,
    VSL_CLK_SUBCARRIER = 2'h1
  } vsl_clk_mode_t;

  typedef enum logic [1:0] {
    VSL_EMU_FULL = 2'h0,
    VSL_EMU_TWO_LINE = 2'h1,
    VSL_EMU_SIMPLE = 2'h2
  } vsl_emu_t;

  // ****************************************
  // Reference word detector states
  // ****************************************
  typedef enum logic [3:0] {
    VSL_REF_IDLE = 4'b0001,
    VSL_REF_ONES = 4'b0010,
    VSL_REF_ZERO1 = 4'b0100,
    VSL_REF_ZERO2 = 4'b1000
  } vsl_ref_state_t;

  // ****************************************
  // Separator states
  // ****************************************
  typedef enum logic [2:0] {
    VSL_SEP_SEARCH = 3'b001,
    VSL_SEP_LOCK = 3'b010,
    VSL_SEP_FLYWHEEL = 3'b100
  } vsl_sep_state_t;

endpackage

// ### rtl/vsl_timing_if.sv
`timescale 1ns/10ps
interface vsl_timing_if;
  logic line_start;
  logic field_start;
  logic field_id;
  logic valid;
  modport src (output line_start, output field_start, output field_id, output valid);
  modport dst (input line_start, input field_start, input field_id, input valid);
endinterface

// ### rtl/vsl_ref_decoder.sv
`timescale 1ns/10ps
module vsl_ref_decoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] word_in,
  vsl_timing_if.src tim
);

  // ****************************************
  // Reference word search
  // ****************************************
  vsl_pkg::vsl_ref_state_t state_q;
  logic h_q;
  logic v_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= vsl_pkg::VSL_REF_IDLE;
    end else begin
      case (state_q)
        vsl_pkg::VSL_REF_IDLE: begin
          if (word_in == vsl_pkg::REF_PREAMBLE_ONES) begin
            state_q <= vsl_pkg::VSL_REF_ONES;
          end
        end
        vsl_pkg::VSL_REF_ONES: begin
          state_q <= (word_in == vsl_pkg::REF_PREAMBLE_ZERO) ? vsl_pkg::VSL_REF_ZERO1
                                                              : vsl_pkg::VSL_REF_IDLE;
        end
        vsl_pkg::VSL_REF_ZERO1: begin
          state_q <= (word_in == vsl_pkg::REF_PREAMBLE_ZERO) ? vsl_pkg::VSL_REF_ZERO2
                                                              : vsl_pkg::VSL_REF_IDLE;
        end
        vsl_pkg::VSL_REF_ZERO2: begin
          state_q <= vsl_pkg::VSL_REF_IDLE;
        end
        default: begin
          state_q <= vsl_pkg::VSL_REF_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Status word decode
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tim.line_start <= 1'b0;
      tim.field_start <= 1'b0;
      tim.field_id <= 1'b0;
      tim.valid <= 1'b0;
      h_q <= 1'b0;
      v_q <= 1'b0;
    end else begin
      tim.line_start <= 1'b0;
      tim.field_start <= 1'b0;
      if (state_q == vsl_pkg::VSL_REF_ZERO2) begin
        tim.valid <= 1'b1;
        h_q <= word_in[vsl_pkg::REF_H_BIT];
        v_q <= word_in[vsl_pkg::REF_V_BIT];
        tim.field_id <= word_in[vsl_pkg::REF_F_BIT];
        tim.line_start <= word_in[vsl_pkg::REF_H_BIT] & ~h_q;
        tim.field_start <= v_q & ~word_in[vsl_pkg::REF_V_BIT];
      end
    end
  end

endmodule

// ### tb/vsl_sync_lock_asserts.sv
`timescale 1ns/10ps
module vsl_sync_lock_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] video_word_in,
  input wire logic clock_subcarrier_mode,
  input wire logic embedded_enable,
  input wire logic [3:0] comb_select_in,
  input wire logic [1:0] emulate_mode,
  input wire logic eight_bit_mode,
  input wire logic [9:0] video_word_out,
  input wire logic decoded_line_sync_out,
  input wire logic decoded_field_sync_out,
  input wire logic field_id_out,
  input wire logic [3:0] comb_arch_out
);
  // ****************************************
  // Reference word tracking and checks
  // ****************************************
  logic [9:0] p1_q, p2_q, p3_q;
  logic h_q, v_q, f_q;
  logic [1:0] age_q;
  logic hit;
  assign hit = p3_q == 10'h3FF && p2_q == 10'h000 && p1_q == 10'h000 && embedded_enable
    && !clock_subcarrier_mode;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p1_q <= 10'h000;
      p2_q <= 10'h000;
      p3_q <= 10'h000;
      age_q <= 2'h0;
    end else begin
      p1_q <= video_word_in;
      p2_q <= p1_q;
      p3_q <= p2_q;
      age_q <= (age_q == 2'h3) ? 2'h3 : age_q + 2'h1;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      h_q <= 1'b0;
      v_q <= 1'b0;
      f_q <= 1'b0;
    end else if (hit) begin
      h_q <= video_word_in[6];
      v_q <= video_word_in[7];
      f_q <= video_word_in[8];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_WORD_MSB: assert property (age_q == 2'h3 |->
    video_word_out[9:2] == $past(video_word_in[9:2], 2)) else $error("upper word bits wrong");
  AST_WORD_LSB: assert property (age_q == 2'h3 && $stable(eight_bit_mode)
    && eight_bit_mode == $past(eight_bit_mode, 2) |-> video_word_out[1:0]
    == (eight_bit_mode ? 2'h0 : $past(video_word_in[1:0], 2))) else $error("low bits wrong");
  AST_COMB_FULL: assert property (age_q != 2'h0 && $stable(comb_select_in)
    && $stable(emulate_mode) && emulate_mode == 2'h0 |-> comb_arch_out == comb_select_in)
    else $error("comb selection wrong");
  AST_COMB_TWO: assert property (age_q != 2'h0 && $stable(comb_select_in)
    && $stable(emulate_mode) && emulate_mode == 2'h1 |-> comb_arch_out == {1'b0,
    comb_select_in[2:0]}) else $error("two-line comb wrong");
  AST_COMB_SIMPLE: assert property (age_q != 2'h0 && $stable(emulate_mode)
    && emulate_mode == 2'h2 |-> comb_arch_out == 4'h0) else $error("simple comb wrong");
  AST_LINE_ALIGN: assert property (hit && video_word_in[6] && !h_q |->
    ##[1:8] decoded_line_sync_out) else $error("line not aligned");
  AST_FIELD_ALIGN: assert property (hit && !video_word_in[7] && v_q |->
    ##[1:8] decoded_field_sync_out) else $error("field not aligned");
  AST_FIELD_ID: assert property (hit && !video_word_in[7] && v_q |->
    ##[1:8] field_id_out == f_q) else $error("field id wrong");
  COV_LINE: cover property (hit && video_word_in[6] && !h_q);
  COV_EIGHT: cover property (eight_bit_mode && age_q == 2'h3);
  COV_SIMPLE: cover property (emulate_mode == 2'h2);
endmodule

bind vsl_sync_lock vsl_sync_lock_asserts u_asserts (
  .clock(clock), .rst_n(rst_n), .video_word_in(video_word_in),
  .clock_subcarrier_mode(clock_subcarrier_mode), .embedded_enable(embedded_enable),
  .comb_select_in(comb_select_in), .emulate_mode(emulate_mode),
  .eight_bit_mode(eight_bit_mode), .video_word_out(video_word_out),
  .decoded_line_sync_out(decoded_line_sync_out),
  .decoded_field_sync_out(decoded_field_sync_out), .field_id_out(field_id_out),
  .comb_arch_out(comb_arch_out)
);

// ### tb/vsl_source_model.sv
`timescale 1ns/10ps
module vsl_source_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic codes,
  input wire logic syncs,
  input wire logic sep,
  output logic [9:0] word,
  output logic line_sync_n,
  output logic field_sync_n
);
  // ****************************************
  // Line of 400 words, field of 12 lines
  // ****************************************
  int cnt;
  int lnum;
  logic fld;
  logic v;
  assign v = lnum < 2;
  always @(negedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      lnum <= 0;
      fld <= 1'b0;
    end else begin
      cnt <= (cnt == 399) ? 0 : cnt + 1;
      if (cnt == 399) begin
        lnum <= (lnum == 11) ? 0 : lnum + 1;
        fld <= (lnum == 11) ? ~fld : fld;
      end
    end
  end
  always_comb begin
    word = 10'h100 + 10'(cnt % 256);
    if (sep && (cnt < 40 || (v && cnt < 300))) word = 10'h010;
    if (codes && cnt % 200 < 3) word = (cnt % 200 == 0) ? 10'h3FF : 10'h000;
    if (codes && cnt % 200 == 3) word = {1'b1, fld, v, cnt < 200, 6'h00};
  end
  assign line_sync_n = !(syncs && cnt < 16);
  assign field_sync_n = !(syncs && v);
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  typedef struct {logic [1:0] emu; logic [3:0] sel; logic eight; logic [9:0] w;
    logic [3:0] comb; logic [9:0] wo;} vsl_row_t;
  vsl_row_t rows [6] = '{'{2'h0, 4'hF, 1'b0, 10'h3A5, 4'hF, 10'h3A5},
    '{2'h1, 4'hF, 1'b0, 10'h2B7, 4'h7, 10'h2B7}, '{2'h2, 4'h9, 1'b1, 10'h2B7, 4'h0, 10'h2B4},
    '{2'h1, 4'h6, 1'b1, 10'h0FF, 4'h6, 10'h0FC}, '{2'h0, 4'h0, 1'b1, 10'h3FF, 4'h0, 10'h3FC},
    '{2'h2, 4'h3, 1'b0, 10'h001, 4'h0, 10'h001}};
  logic clock = 1'b0, rst_n = 1'b0, use_m = 1'b0, codes = 1'b0, syncs = 1'b0, sep = 1'b0;
  logic sub = 1'b0, emb = 1'b0, ntsc = 1'b0, eight = 1'b0;
  logic [9:0] tb_word = 10'h155, m_word, word_out;
  logic [3:0] sel = 4'h0, comb_out;
  logic [1:0] emu = 2'h0;
  logic ls_n, fs_n, dls, dfs, fid, locked;
  logic [15:0] n;
  int miscompares = 0, checks_done = 0, k;
  always #5 clock = ~clock;
  vsl_source_model u_src (.clock(clock), .rst_n(rst_n), .codes(codes), .syncs(syncs),
    .sep(sep), .word(m_word), .line_sync_n(ls_n), .field_sync_n(fs_n));
  vsl_sync_lock dut (.clock(clock), .rst_n(rst_n), .video_word_in(use_m ? m_word : tb_word),
    .line_sync_in_n(ls_n), .field_sync_in_n(fs_n), .clock_subcarrier_mode(sub),
    .embedded_enable(emb), .ntsc_4fsc(ntsc), .comb_select_in(sel), .emulate_mode(emu),
    .eight_bit_mode(eight), .video_word_out(word_out), .decoded_line_sync_out(dls),
    .decoded_field_sync_out(dfs), .field_id_out(fid), .timing_locked(locked),
    .comb_arch_out(comb_out));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    check({word_out, comb_out, dls, dfs}, 16'h0000);
    check({fid, locked}, 16'h0000);
    rst_n = 1'b1;
  endtask
  task automatic gap(input logic f, output logic [15:0] n);
    logic p;
    int r;
    r = 0;
    n = 16'h0000;
    p = 1'b1;
    for (int i = 0; i < 20000 && r < 2; i++) begin
      @(negedge clock);
      if (r == 1) n++;
      if ((f ? dfs : dls) === 1'b1 && p === 1'b0) r++;
      p = f ? dfs : dls;
    end
  endtask
  initial begin
    #800000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    @(negedge clock);
    do_reset();
    foreach (rows[i]) begin
      {emu, sel, eight, tb_word} = {rows[i].emu, rows[i].sel, rows[i].eight, rows[i].w};
      repeat (3) @(negedge clock);
      check(comb_out, rows[i].comb);
      check(word_out, rows[i].wo);
    end
    emu = 2'h0;
    for (k = 0; k < 16; k++) begin
      sel = 4'(k);
      repeat (2) @(negedge clock);
      check(comb_out, 16'(k));
    end
    {use_m, codes, emb} = 3'b111;
    gap(1'b0, n);
    check(n, 16'd400);
    gap(1'b1, n);
    check(n, 16'd4800);
    {codes, emb, syncs} = 3'b001;
    gap(1'b0, n);
    check(n, 16'd400);
    gap(1'b1, n);
    check(n, 16'd4800);
    {syncs, ntsc, sub} = 3'b011;
    do_reset();
    gap(1'b0, n);
    check(n, 16'(vsl_pkg::LINE_LEN_RESET));
    sep = 1'b1;
    repeat (24000) @(negedge clock);
    check(locked, 16'h0001);
    gap(1'b0, n);
    check(n, 16'd400);
    n = 16'h0000;
    repeat (4800) begin
      @(negedge clock);
      if (locked !== 1'b1) n++;
    end
    check(n, 16'h0000);
    report_and_stop();
  end
endmodule
